// *** rtl/cdr_ram.sv ***
`timescale 1ns/1ps
module cdr_ram
    import cdr_pkg::*;
(
    input wire logic clk,                    // system clock
    input wire logic rst_n,                  // synchronous reset, active low
    input wire logic byte_mode,              // 1: per-byte enables, 0: any enable writes whole word
    input wire cdr_mode_t mode_a,            // port A write mode
    input wire cdr_mode_t mode_b,            // port B write mode
    input wire logic oreg_a,                 // port A extra output register stage
    input wire logic oreg_b,                 // port B extra output register stage
    input wire logic en_a,                   // port A access enable
    input wire logic [A_BE_W-1:0] we_a,      // port A byte write enables
    input wire logic [A_ADDR_W-1:0] addr_a,  // port A address
    input wire logic [A_WR_W-1:0] din_a,     // port A write data
    input wire logic ssr_a,                  // port A output register clear
    output logic [A_RD_W-1:0] dout_a,        // port A read data
    output logic wr_drop_a,                  // port A out-of-range write dropped
    input wire logic en_b,                   // port B access enable
    input wire logic [B_BE_W-1:0] we_b,      // port B byte write enables
    input wire logic [B_ADDR_W-1:0] addr_b,  // port B address
    input wire logic [B_WR_W-1:0] din_b,     // port B write data
    input wire logic ssr_b,                  // port B output register clear
    output logic [B_RD_W-1:0] dout_b,        // port B read data
    output logic wr_drop_b,                  // port B out-of-range write dropped
    output logic cfg_ok                      // configuration legal
);
    // ratio a:b is a power of two no larger than lim
    function automatic bit pow2_within(input int a, input int b, input int lim);
        int hi;
        int lo;
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        return (hi % lo == 0) && ((hi / lo) <= lim) && (((hi / lo) & ((hi / lo) - 1)) == 0);
    endfunction

    // first storage unit of an access; dropped low bits come from the shift
    function automatic logic [IDX_W:0] unit_idx(input logic [A_ADDR_W-1:0] addr, input int shift,
                                                input int units);
        return (IDX_W+1)'((int'(addr) >> shift) * units);
    endfunction

    // whole access lies inside the configured depth
    function automatic bit in_range(input logic [IDX_W:0] idx, input int units);
        return (int'(idx) + units) <= UNITS;
    endfunction

    // read window overlaid with the enabled bytes of the write word
    function automatic logic [RD_MAX_W-1:0] wf_merge(input logic [RD_MAX_W-1:0] old,
                                                     input logic [WR_MAX_W-1:0] din,
                                                     input logic [BE_MAX_W-1:0] be,
                                                     input int off, input int rd_bytes);
        logic [RD_MAX_W-1:0] res;
        res = old;
        for (int k = 0; k < RD_MAX_W / BYTE_W; k++) begin
            if (k < rd_bytes && be[off*UNIT_BYTES+k]) begin
                res[k*BYTE_W +: BYTE_W] = din[(off*UNIT_BYTES+k)*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction

    // static limits of the fixed view widths
    localparam int W_MAX = (A_WR_W > B_WR_W ? A_WR_W : B_WR_W) > (A_RD_W > B_RD_W ? A_RD_W : B_RD_W)
                         ? (A_WR_W > B_WR_W ? A_WR_W : B_WR_W) : (A_RD_W > B_RD_W ? A_RD_W : B_RD_W);
    localparam int W_MIN = (A_WR_W < B_WR_W ? A_WR_W : B_WR_W) < (A_RD_W < B_RD_W ? A_RD_W : B_RD_W)
                         ? (A_WR_W < B_WR_W ? A_WR_W : B_WR_W) : (A_RD_W < B_RD_W ? A_RD_W : B_RD_W);
    localparam bit SIZE_OK = (W_MIN >= 1) && (W_MAX <= MAX_W)
                           && ((UNITS / A_WR_U) >= MIN_DEPTH) && ((UNITS / B_WR_U) >= MIN_DEPTH);
    localparam bit PORT_OK = pow2_within(A_WR_W, B_WR_W, MAX_RATIO)
                           && pow2_within(A_RD_W, B_RD_W, MAX_RATIO);
    localparam bit SPLIT_OK = pow2_within(A_RD_W, A_WR_W, MAX_RATIO)
                            && pow2_within(B_RD_W, B_WR_W, MAX_RATIO);
    localparam bit SPAN_OK = pow2_within(W_MAX, W_MIN, MAX_RATIO);
    localparam bit DEPTH_OK = (UNITS % A_WR_U == 0) && (UNITS % B_WR_U == 0)
                            && (UNITS % A_RD_U == 0) && (UNITS % B_RD_U == 0);
    localparam bit BW_OK = pow2_within(W_MAX, W_MIN, BW_MAX_RATIO);
    localparam bit PRIM_OK = (W_MIN >= A_WR_W / PRIM_W) && (W_MAX <= A_WR_W * PRIM_SPAN / PRIM_W);
    localparam bit BYTE_OK = (BYTE_W == BYTE_W_SMALL || BYTE_W == BYTE_W_PARITY)
                           && (W_MIN % BYTE_W == 0);
    localparam bit STATIC_OK = SIZE_OK && PORT_OK && SPLIT_OK && SPAN_OK && DEPTH_OK && PRIM_OK && BYTE_OK;

    cdr_mem_if mif ();

    cdr_store u_store (
        .clk (clk),
        .mif (mif)
    );

    // core read registers, one cycle after the access
    logic [A_RD_W-1:0] core_a;
    logic [B_RD_W-1:0] core_b;
    logic [A_RD_W-1:0] next_core_a;
    logic [B_RD_W-1:0] next_core_b;

    // port A decode and read result

    // hold mode cannot be honoured per byte, so it falls back to read-first
    wire a_hold_refused = byte_mode && (mode_a == CDR_HOLD);
    wire cdr_mode_t a_mode = a_hold_refused ? CDR_RD_FIRST : mode_a;
    wire a_wr_req = en_a && (|we_a);
    // whole-word mode turns any enable into all lanes
    wire [A_BE_W-1:0] a_be = byte_mode ? we_a : {A_BE_W{|we_a}};

    // address decode: write view drops its low bit, read view uses all bits
    wire [IDX_W:0] a_wr_idx = unit_idx(addr_a, A_WR_SHIFT, A_WR_U);
    wire [IDX_W:0] a_rd_idx = unit_idx(addr_a, A_RD_SHIFT, A_RD_U);
    wire a_wr_ok = in_range(a_wr_idx, A_WR_U);
    wire a_rd_ok = in_range(a_rd_idx, A_RD_U);
    // read window offset inside the write word, in units
    wire [2:0] a_off = 3'(a_rd_idx - a_wr_idx);

    // old data; beyond the depth the array output is replaced by zero
    wire [A_RD_W-1:0] a_old = a_rd_ok ? mif.ra_data : '0;
    wire [RD_MAX_W-1:0] a_merged = wf_merge(RD_MAX_W'(a_old), WR_MAX_W'(din_a), BE_MAX_W'(a_be),
                                            int'(a_off), A_RD_U * UNIT_BYTES);

    assign mif.wa_en = a_wr_req && a_wr_ok;
    assign mif.wa_idx = a_wr_idx[IDX_W-1:0];
    assign mif.wa_data = din_a;
    assign mif.wa_be = a_be;
    assign mif.ra_idx = a_rd_idx[IDX_W-1:0];

    // what the port A read output shows after this access
    always_comb begin
        next_core_a = core_a;
        if (en_a && !a_wr_req) begin
            next_core_a = a_old;
        end else if (a_wr_req) begin
            unique case (a_mode)
                CDR_WR_FIRST: next_core_a = a_merged[A_RD_W-1:0];
                CDR_RD_FIRST: next_core_a = a_old;
                CDR_HOLD: next_core_a = core_a;
                default: next_core_a = core_a;
            endcase
        end
    end

    // port B decode and read result

    wire b_hold_refused = byte_mode && (mode_b == CDR_HOLD);
    wire cdr_mode_t b_mode = b_hold_refused ? CDR_RD_FIRST : mode_b;
    wire b_wr_req = en_b && (|we_b);
    wire [B_BE_W-1:0] b_be = byte_mode ? we_b : {B_BE_W{|we_b}};

    wire [IDX_W:0] b_wr_idx = unit_idx(A_ADDR_W'(addr_b), B_WR_SHIFT, B_WR_U);
    wire [IDX_W:0] b_rd_idx = unit_idx(A_ADDR_W'(addr_b), B_RD_SHIFT, B_RD_U);
    wire b_wr_ok = in_range(b_wr_idx, B_WR_U);
    wire b_rd_ok = in_range(b_rd_idx, B_RD_U);
    wire [2:0] b_off = 3'(b_rd_idx - b_wr_idx);

    wire [B_RD_W-1:0] b_old = b_rd_ok ? mif.rb_data : '0;
    wire [RD_MAX_W-1:0] b_merged = wf_merge(RD_MAX_W'(b_old), WR_MAX_W'(din_b), BE_MAX_W'(b_be),
                                            int'(b_off), B_RD_U * UNIT_BYTES);

    assign mif.wb_en = b_wr_req && b_wr_ok;
    assign mif.wb_idx = b_wr_idx[IDX_W-1:0];
    assign mif.wb_data = din_b;
    assign mif.wb_be = b_be;
    assign mif.rb_idx = b_rd_idx[IDX_W-1:0];

    // what the port B read output shows after this access
    always_comb begin
        next_core_b = core_b;
        if (en_b && !b_wr_req) begin
            next_core_b = b_old;
        end else if (b_wr_req) begin
            unique case (b_mode)
                CDR_WR_FIRST: next_core_b = b_merged[B_RD_W-1:0];
                CDR_RD_FIRST: next_core_b = b_old;
                CDR_HOLD: next_core_b = core_b;
                default: next_core_b = core_b;
            endcase
        end
    end

    // state registers

    // core read stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_a <= '0;
            core_b <= '0;
        end else begin
            core_a <= next_core_a;
            core_b <= next_core_b;
        end
    end

    // last output stage: bypass keeps one-cycle latency, stage adds one more;
    // clearing it on an out-of-range access is left to the user to avoid
    always_ff @(posedge clk) begin
        if (!rst_n || ssr_a) begin
            dout_a <= '0;
        end else begin
            dout_a <= oreg_a ? core_a : next_core_a;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || ssr_b) begin
            dout_b <= '0;
        end else begin
            dout_b <= oreg_b ? core_b : next_core_b;
        end
    end

    // status: one-cycle pulse per dropped write, level for configuration
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_drop_a <= 1'h0;
            wr_drop_b <= 1'h0;
            cfg_ok <= 1'h0;
        end else begin
            wr_drop_a <= a_wr_req && !a_wr_ok;
            wr_drop_b <= b_wr_req && !b_wr_ok;
            cfg_ok <= STATIC_OK && !a_hold_refused && !b_hold_refused
                      && (!byte_mode || BW_OK);
        end
    end
endmodule

// *** rtl/cdr_pkg.sv ***
package cdr_pkg;
    // byte lanes: 9-bit bytes, ninth bit of each byte carries parity
    localparam int BYTE_W = 9;
    localparam int UNIT_BYTES = 2;
    localparam int UNIT_W = BYTE_W * UNIT_BYTES;
    // storage in narrowest units; 1000 is not a power of two, so the top addresses fall out of range
    localparam int UNITS = 1000;
    localparam int IDX_W = 10;
    // units per access for each of the four data views
    localparam int A_WR_U = 2;
    localparam int A_RD_U = 1;
    localparam int B_WR_U = 4;
    localparam int B_RD_U = 2;
    localparam int A_WR_W = A_WR_U * UNIT_W;
    localparam int A_RD_W = A_RD_U * UNIT_W;
    localparam int B_WR_W = B_WR_U * UNIT_W;
    localparam int B_RD_W = B_RD_U * UNIT_W;
    localparam int A_BE_W = A_WR_U * UNIT_BYTES;
    localparam int B_BE_W = B_WR_U * UNIT_BYTES;
    // address buses sized for the deeper view; shallower view drops low bits
    localparam int A_ADDR_W = 10;
    localparam int B_ADDR_W = 9;
    localparam int A_WR_SHIFT = 1;
    localparam int A_RD_SHIFT = 0;
    localparam int B_WR_SHIFT = 1;
    localparam int B_RD_SHIFT = 0;
    // widest views used by the shared merge helper
    localparam int RD_MAX_W = B_RD_W;
    localparam int WR_MAX_W = B_WR_W;
    localparam int BE_MAX_W = B_BE_W;
    // configuration limits
    localparam int MAX_W = 4608;
    localparam int MIN_DEPTH = 2;
    localparam int MAX_RATIO = 32;
    localparam int BW_MAX_RATIO = 4;
    localparam int PRIM_W = 9;
    localparam int PRIM_SPAN = 32;
    localparam int BYTE_W_SMALL = 8;
    localparam int BYTE_W_PARITY = 9;

    // per-port write modes
    typedef enum logic [2:0] {
        CDR_WR_FIRST = 3'h1,
        CDR_RD_FIRST = 3'h2,
        CDR_HOLD = 3'h4
    } cdr_mode_t;
endpackage

// *** rtl/cdr_mem_if.sv ***
`timescale 1ns/1ps
interface cdr_mem_if;
    import cdr_pkg::*;
    logic wa_en;
    logic [IDX_W-1:0] wa_idx;
    logic [A_WR_W-1:0] wa_data;
    logic [A_BE_W-1:0] wa_be;
    logic wb_en;
    logic [IDX_W-1:0] wb_idx;
    logic [B_WR_W-1:0] wb_data;
    logic [B_BE_W-1:0] wb_be;
    logic [IDX_W-1:0] ra_idx;
    logic [A_RD_W-1:0] ra_data;
    logic [IDX_W-1:0] rb_idx;
    logic [B_RD_W-1:0] rb_data;

    modport core (
        output wa_en, wa_idx, wa_data, wa_be,
        output wb_en, wb_idx, wb_data, wb_be,
        output ra_idx, rb_idx,
        input ra_data, rb_data
    );
    modport store (
        input wa_en, wa_idx, wa_data, wa_be,
        input wb_en, wb_idx, wb_data, wb_be,
        input ra_idx, rb_idx,
        output ra_data, rb_data
    );
endinterface

// *** rtl/cdr_store.sv ***
`timescale 1ns/1ps
module cdr_store
    import cdr_pkg::*;
(
    input wire logic clk, // memory clock
    cdr_mem_if.store mif  // access from the port logic
);
    logic [UNIT_W-1:0] mem [UNITS];

    // byte-lane writes; port B applies last, so a same-byte collision keeps B
    always_ff @(posedge clk) begin
        if (mif.wa_en) begin
            for (int u = 0; u < A_WR_U; u++) begin
                for (int b = 0; b < UNIT_BYTES; b++) begin
                    if (mif.wa_be[u*UNIT_BYTES+b]) begin
                        mem[int'(mif.wa_idx)+u][b*BYTE_W +: BYTE_W] <=
                            mif.wa_data[(u*UNIT_BYTES+b)*BYTE_W +: BYTE_W];
                    end
                end
            end
        end
        if (mif.wb_en) begin
            for (int u = 0; u < B_WR_U; u++) begin
                for (int b = 0; b < UNIT_BYTES; b++) begin
                    if (mif.wb_be[u*UNIT_BYTES+b]) begin
                        mem[int'(mif.wb_idx)+u][b*BYTE_W +: BYTE_W] <=
                            mif.wb_data[(u*UNIT_BYTES+b)*BYTE_W +: BYTE_W];
                    end
                end
            end
        end
    end

    // reads see the contents before this edge's write; lowest unit in low bits
    for (genvar u = 0; u < A_RD_U; u++) begin : g_ra
        assign mif.ra_data[u*UNIT_W +: UNIT_W] = mem[IDX_W'(int'(mif.ra_idx)+u)];
    end
    for (genvar u = 0; u < B_RD_U; u++) begin : g_rb
        assign mif.rb_data[u*UNIT_W +: UNIT_W] = mem[IDX_W'(int'(mif.rb_idx)+u)];
    end
endmodule

// *** tb/cdr_ram_chk.sv ***
`timescale 1ns/1ps
module cdr_ram_chk
    import cdr_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic byte_mode, // byte mode
    input wire cdr_mode_t mode_a, // mode A
    input wire cdr_mode_t mode_b, // mode B
    input wire logic oreg_a, // stage A
    input wire logic oreg_b, // stage B
    input wire logic en_a, // enable A
    input wire logic [A_BE_W-1:0] we_a, // write A
    input wire logic [A_ADDR_W-1:0] addr_a, // addr A
    input wire logic [A_WR_W-1:0] din_a, // data in A
    input wire logic ssr_a, // clear A
    input wire logic [A_RD_W-1:0] dout_a, // data out A
    input wire logic wr_drop_a, // drop A
    input wire logic en_b, // enable B
    input wire logic [B_BE_W-1:0] we_b, // write B
    input wire logic [B_ADDR_W-1:0] addr_b, // addr B
    input wire logic [B_WR_W-1:0] din_b, // data in B
    input wire logic ssr_b, // clear B
    input wire logic [B_RD_W-1:0] dout_b, // data out B
    input wire logic wr_drop_b, // drop B
    input wire logic cfg_ok // legal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // any enable bit makes a write; drops are judged on the whole word
    wire wr_a = en_a && (|we_a);
    wire wr_b = en_b && (|we_b);
    wire drop_a = wr_a && addr_a >= 10'h3E8;
    wire drop_b = wr_b && addr_b >= 9'h1F4;
    wire hold_bad = byte_mode && (mode_a == CDR_HOLD || mode_b == CDR_HOLD);
    // plain write-first value is only promised for whole-word writes without extra stage
    wire wf_a = wr_a && !drop_a && !byte_mode && !oreg_a && !ssr_a && mode_a == CDR_WR_FIRST;
    wire wf_b = wr_b && !drop_b && !byte_mode && !oreg_b && !ssr_b && mode_b == CDR_WR_FIRST;
    wire [17:0] half_a = addr_a[0] ? din_a[35:18] : din_a[17:0];
    wire [35:0] half_b = addr_b[0] ? din_b[71:36] : din_b[35:0];

    property p_drop_a; $past(rst_n) |-> wr_drop_a == $past(drop_a); endproperty
    a_drop_a: assert property (p_drop_a) else $error("port A drop flag wrong");
    property p_drop_b; $past(rst_n) |-> wr_drop_b == $past(drop_b); endproperty
    a_drop_b: assert property (p_drop_b) else $error("port B drop flag wrong");
    property p_cfg; $past(rst_n) |-> cfg_ok == !$past(hold_bad); endproperty
    a_cfg: assert property (p_cfg) else $error("legal flag wrong");
    property p_hold; wr_a && mode_a == CDR_HOLD && !byte_mode && !oreg_a && !ssr_a |=> $stable(dout_a); endproperty
    a_hold: assert property (p_hold) else $error("hold write moved output");
    property p_wf_a; wf_a |=> dout_a == $past(half_a); endproperty
    a_wf_a: assert property (p_wf_a) else $error("port A write-first data wrong");
    property p_wf_b; wf_b |=> dout_b == $past(half_b); endproperty
    a_wf_b: assert property (p_wf_b) else $error("port B write-first data wrong");
    property p_ssr; ssr_a |=> dout_a == 18'h00000; endproperty
    a_ssr: assert property (p_ssr) else $error("output clear failed");
    property p_idle; !en_a && !ssr_a && !oreg_a && !$past(oreg_a) |=> $stable(dout_a); endproperty
    a_idle: assert property (p_idle) else $error("output moved without access");
    c_wf: cover property (wf_a);
    c_drop: cover property (drop_b);
    c_hold: cover property (wr_a && mode_a == CDR_HOLD);
endmodule

// *** tb/cdr_user_b.sv ***
`timescale 1ns/1ps
module cdr_user_b
    import cdr_pkg::*;
(
    input wire logic clk, // clock
    output logic en_b, // access enable
    output logic [B_BE_W-1:0] we_b, // byte enables
    output logic [B_ADDR_W-1:0] addr_b, // address
    output logic [B_WR_W-1:0] din_b, // write data
    output logic ssr_b // clear, never pulsed
);
    // clear stays low so no out-of-range access ever meets it
    initial begin
        en_b = 1'b0;
        we_b = 8'h00;
        addr_b = 9'h000;
        din_b = 72'h0;
        ssr_b = 1'b0;
    end
    // launched off the falling edge, held over one rising edge; idle data is inverted so stale words never match
    task automatic access(input logic [7:0] be, input logic [8:0] a, input logic [71:0] d);
        @(negedge clk);
        en_b = 1'b1;
        we_b = be;
        addr_b = a;
        din_b = d;
        @(negedge clk);
        en_b = 1'b0;
        we_b = 8'h00;
        din_b = ~d;
    endtask
endmodule

// *** tb/cdr_ram_tb.sv ***
`timescale 1ns/1ps
module cdr_ram_tb
    import cdr_pkg::*;
();
    localparam logic [35:0] X = 36'h123456789;
    localparam logic [35:0] Y = 36'hABCDE0123;
    localparam logic [35:0] Z = 36'h5A5A5A5A5;
    localparam logic [35:0] W = 36'hF0F0F0F0F;
    // byte 1 of a 36-bit word, bits 17:9
    localparam logic [35:0] M = 36'h00003FE00;
    localparam logic [35:0] ZW = (Z & ~M) | (W & M);
    localparam logic [71:0] V = 72'h0123456789ABCDEF01;
    logic clk = 1'b0, rst_n = 1'b0, byte_mode = 1'b0;
    logic oreg_a = 1'b0, oreg_b = 1'b0, en_a = 1'b0, ssr_a = 1'b0;
    cdr_mode_t mode_a = CDR_WR_FIRST, mode_b = CDR_WR_FIRST;
    logic [A_BE_W-1:0] we_a = 4'h0;
    logic [A_ADDR_W-1:0] addr_a = 10'h000;
    logic [A_WR_W-1:0] din_a = 36'h000000000;
    logic [A_RD_W-1:0] dout_a;
    logic [B_RD_W-1:0] dout_b;
    logic en_b, ssr_b, wr_drop_a, wr_drop_b, cfg_ok;
    logic [B_BE_W-1:0] we_b;
    logic [B_ADDR_W-1:0] addr_b;
    logic [B_WR_W-1:0] din_b;
    int miscompares = 0, tests_run = 0, cycles = 0;

    cdr_ram DUT (
        .clk, .rst_n, .byte_mode, .mode_a, .mode_b, .oreg_a, .oreg_b,
        .en_a, .we_a, .addr_a, .din_a, .ssr_a, .dout_a, .wr_drop_a,
        .en_b, .we_b, .addr_b, .din_b, .ssr_b, .dout_b, .wr_drop_b, .cfg_ok
    );
    // far-side user logic on port B
    cdr_user_b u_b (.clk, .en_b, .we_b, .addr_b, .din_b, .ssr_b);

    initial begin
        forever #10 clk = ~clk;
    end
    // cut a hang short well past the roughly fifty cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // one port A access off the falling edge; returns once the answer has landed
    task automatic acc_a(input logic [3:0] be, input logic [9:0] a, input logic [35:0] d);
        @(negedge clk);
        en_a = 1'b1;
        we_a = be;
        addr_a = a;
        din_a = d;
        @(negedge clk);
        en_a = 1'b0;
        we_a = 4'h0;
        din_a = ~d;
    endtask

    task automatic t_modes;
        acc_a(4'hF, 10'h002, X);
        chk(72'(dout_a), 72'(X[17:0]));
        acc_a(4'h0, 10'h003, Y);
        chk(72'(dout_a), 72'(X[35:18]));
        mode_a = CDR_RD_FIRST;
        acc_a(4'hF, 10'h002, Y);
        chk(72'(dout_a), 72'(X[17:0]));
        mode_a = CDR_HOLD;
        acc_a(4'h0, 10'h002, X);
        acc_a(4'hF, 10'h002, Z);
        chk(72'(dout_a), 72'(Y[17:0]));
        chk_flag(cfg_ok, 1'b1);
        u_b.access(8'h00, 9'h001, V);
        chk(72'(dout_b), 72'(Z));
    endtask
    // partial write, then hold mode with byte enables falls back to read-first
    task automatic t_bytes;
        byte_mode = 1'b1;
        mode_a = CDR_RD_FIRST;
        acc_a(4'h2, 10'h002, W);
        u_b.access(8'h00, 9'h001, V);
        chk(72'(dout_b), 72'(ZW));
        mode_a = CDR_HOLD;
        acc_a(4'h1, 10'h002, X);
        chk(72'(dout_a), 72'(ZW[17:0]));
        chk_flag(cfg_ok, 1'b0);
        byte_mode = 1'b0;
        mode_a = CDR_RD_FIRST;
    endtask
    task automatic t_wide;
        u_b.access(8'hFF, 9'h000, V);
        chk(72'(dout_b), 72'(V[35:0]));
        chk_flag(wr_drop_b, 1'b0);
        // port B modes: odd address picks the upper half, so the three modes differ
        mode_b = CDR_RD_FIRST;
        u_b.access(8'hFF, 9'h000, ~V);
        chk(72'(dout_b), 72'(V[35:0]));
        mode_b = CDR_HOLD;
        u_b.access(8'hFF, 9'h001, V);
        chk(72'(dout_b), 72'(V[35:0]));
        u_b.access(8'h00, 9'h001, 72'h0);
        chk(72'(dout_b), 72'(V[71:36]));
        mode_b = CDR_WR_FIRST;
        // extra stage on port B: the new word shows one cycle late
        oreg_b = 1'b1;
        u_b.access(8'h00, 9'h000, 72'h0);
        chk(72'(dout_b), 72'(V[71:36]));
        @(negedge clk);
        chk(72'(dout_b), 72'(V[35:0]));
        oreg_b = 1'b0;
        for (int i = 0; i < 4; i++) begin
            acc_a(4'h0, 10'(i), 36'h000000000);
            chk(72'(dout_a), 72'(V[18*i +: 18]));
        end
    endtask
    task automatic t_range;
        acc_a(4'hF, 10'h3E8, X);
        chk_flag(wr_drop_a, 1'b1);
        u_b.access(8'hFF, 9'h1F4, 72'h0);
        chk_flag(wr_drop_b, 1'b1);
        acc_a(4'h0, 10'h000, X);
        chk(72'(dout_a), 72'(V[17:0]));
        chk_flag(wr_drop_a, 1'b0);
    endtask
    // unit 5 holds a word never read before, so a stale output cannot match it
    task automatic t_oreg;
        acc_a(4'hF, 10'h004, Y);
        oreg_a = 1'b1;
        @(negedge clk);
        en_a = 1'b1;
        addr_a = 10'h005;
        @(negedge clk);
        addr_a = 10'h004;
        chk_flag(dout_a === Y[35:18], 1'b0);
        @(negedge clk);
        en_a = 1'b0;
        chk(72'(dout_a), 72'(Y[35:18]));
        oreg_a = 1'b0;
        ssr_a = 1'b1;
        @(negedge clk);
        ssr_a = 1'b0;
        chk(72'(dout_a), 72'h0);
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_modes();
        t_bytes();
        t_wide();
        t_range();
        t_oreg();
        close_out();
    end
endmodule

bind cdr_ram cdr_ram_chk u_chk (
    .clk, .rst_n, .byte_mode, .mode_a, .mode_b, .oreg_a, .oreg_b,
    .en_a, .we_a, .addr_a, .din_a, .ssr_a, .dout_a, .wr_drop_a,
    .en_b, .we_b, .addr_b, .din_b, .ssr_b, .dout_b, .wr_drop_b, .cfg_ok
);
